// *** design/fpp_cfg.svh ***
`ifndef FPP_CFG_SVH
`define FPP_CFG_SVH
// timing figures in ns
`define FPP_CLK_PERIOD_NS 40
`define FPP_DELAY_MIN_NS 100
`define FPP_FUSE1_MIN_NS 40000
`define FPP_FUSE2_MIN_NS 4000000
`define FPP_SENSE_MAX_NS 500
`define FPP_PWRUP_MAX_NS 1000
// derived cycle counts: least times and the power-up time round up, the longest sense time rounds down
`define FPP_DELAY_CYC ((`FPP_DELAY_MIN_NS + `FPP_CLK_PERIOD_NS - 1) / `FPP_CLK_PERIOD_NS)
`define FPP_FUSE1_CYC ((`FPP_FUSE1_MIN_NS + `FPP_CLK_PERIOD_NS - 1) / `FPP_CLK_PERIOD_NS)
`define FPP_FUSE2_CYC ((`FPP_FUSE2_MIN_NS + `FPP_CLK_PERIOD_NS - 1) / `FPP_CLK_PERIOD_NS)
`define FPP_SENSE_CYC (`FPP_SENSE_MAX_NS / `FPP_CLK_PERIOD_NS)
`define FPP_PWRUP_CYC ((`FPP_PWRUP_MAX_NS + `FPP_CLK_PERIOD_NS - 1) / `FPP_CLK_PERIOD_NS)
// address layout
`define FPP_ROW_W 6
`define FPP_COL_W 4
`define FPP_OUT_N 8
`define FPP_ARCH_ROW 6'h3F
`define FPP_ROW_LAST 6'h27
`endif

// *** design/fpp_host.sv ***
`timescale 1ns/10ps
`include "fpp_cfg.svh"
module fpp_host #(
   parameter int OUT_N = `FPP_OUT_N,
   parameter int FUSE1_CYC = `FPP_FUSE1_CYC,
   parameter int FUSE2_CYC = `FPP_FUSE2_CYC
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [1:0] cmd_op,
   input wire logic [`FPP_ROW_W-1:0] cmd_row,
   input wire logic [`FPP_COL_W-1:0] cmd_col,
   input wire logic [OUT_N-1:0] cmd_outsel,
   input wire logic [OUT_N-1:0] cmd_expect,
   output logic rsp_valid,
   output logic rsp_pass,
   output logic rsp_retried,
   output logic [OUT_N-1:0] rsp_data,
   output logic [`FPP_ROW_W-1:0] row_addr_o,
   output logic [`FPP_COL_W-1:0] col_addr_o,
   output logic first_output_supply,
   output logic second_output_supply,
   output logic latch_force_load,
   output logic latch_transparency_control,
   output logic [OUT_N-1:0] dout_o,
   output logic [OUT_N-1:0] dout_oe,
   input wire logic [OUT_N-1:0] din_i
);
   // ---------------------------------------------------------------
   // constants
   // ---------------------------------------------------------------
   localparam int DLY_CYC = `FPP_DELAY_CYC;
   localparam int SNS_CYC = `FPP_SENSE_CYC;
   localparam int PWR_CYC = `FPP_PWRUP_CYC;
   localparam int CNT_W = 20;

   // ---------------------------------------------------------------
   // pin input synchroniser
   // ---------------------------------------------------------------
   logic [OUT_N-1:0] din_s;
   fpp_sync #(.WIDTH(OUT_N)) u_sync (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .async_in(din_i),
      .sync_out(din_s)
   );

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   fpp_pkg::fpp_state_t st_q, st_d;
   fpp_pkg::fpp_op_t op_q, op_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic pwr_ok_q, pwr_ok_d;
   logic retry_q, retry_d;
   logic [`FPP_ROW_W-1:0] row_q, row_d;
   logic [`FPP_COL_W-1:0] col_q, col_d;
   logic [OUT_N-1:0] sel_q, sel_d, exp_q, exp_d;
   logic vo1_q, vo1_d, vo2_q, vo2_d, pl_q, pl_d, le_q, le_d;
   logic [OUT_N-1:0] do_q, do_d, oe_q, oe_d;
   logic rv_q, rv_d, rp_q, rp_d, rr_q, rr_d;
   logic [OUT_N-1:0] rd_q, rd_d;
   logic cnt_done;
   logic sense_ok;

   assign cnt_done = (cnt_q == '0);
   // compares only the outputs in the selection mask
   assign sense_ok = ((din_s ^ exp_q) & sel_q) == '0;

   always_comb begin
      st_d = st_q;
      op_d = op_q;
      cnt_d = cnt_done ? cnt_q : cnt_q - 1'b1;
      pwr_ok_d = pwr_ok_q;
      retry_d = retry_q;
      row_d = row_q;
      col_d = col_q;
      sel_d = sel_q;
      exp_d = exp_q;
      vo1_d = vo1_q;
      vo2_d = vo2_q;
      pl_d = pl_q;
      le_d = le_q;
      do_d = do_q;
      oe_d = oe_q;
      rv_d = 1'b0;
      rp_d = rp_q;
      rr_d = rr_q;
      rd_d = rd_q;
      if (!pwr_ok_q && cnt_done) begin
         pwr_ok_d = 1'b1;
      end
      unique case (st_q)
         fpp_pkg::FPP_IDLE: begin
            // latches stay opaque until power-up clear time has run out
            if (cmd_valid && pwr_ok_q) begin
               op_d = fpp_pkg::fpp_op_t'(cmd_op);
               row_d = cmd_row;
               col_d = cmd_col;
               sel_d = cmd_outsel;
               exp_d = cmd_expect;
               retry_d = 1'b0;
               cnt_d = CNT_W'(DLY_CYC);
               st_d = (fpp_pkg::fpp_op_t'(cmd_op) == fpp_pkg::FPP_OP_LATCH_FORCE_LOAD) ?
                      fpp_pkg::FPP_PL_ON : fpp_pkg::FPP_SETUP;
            end
         end
         fpp_pkg::FPP_SETUP: begin
            le_d = 1'b1;
            if (cnt_done) begin
               vo1_d = 1'b1;
               cnt_d = CNT_W'(DLY_CYC);
               st_d = fpp_pkg::FPP_VER_ON;
            end
         end
         fpp_pkg::FPP_VER_ON: begin
            if (cnt_done) begin
               cnt_d = CNT_W'(DLY_CYC);
               if (op_q == fpp_pkg::FPP_OP_PROG) begin
                  vo2_d = 1'b1;
                  st_d = fpp_pkg::FPP_PRG_ON;
               end else begin
                  le_d = 1'b0;
                  st_d = fpp_pkg::FPP_LE_LOW;
               end
            end
         end
         fpp_pkg::FPP_PRG_ON: begin
            if (cnt_done) begin
               do_d = sel_q;
               oe_d = sel_q;
               cnt_d = retry_q ? CNT_W'(FUSE2_CYC) : CNT_W'(FUSE1_CYC);
               st_d = fpp_pkg::FPP_FUSE;
            end
         end
         fpp_pkg::FPP_FUSE: begin
            if (cnt_done) begin
               do_d = '0;
               oe_d = '0;
               cnt_d = CNT_W'(DLY_CYC);
               st_d = fpp_pkg::FPP_PRG_OFF;
            end
         end
         fpp_pkg::FPP_PRG_OFF: begin
            vo2_d = 1'b0;
            if (cnt_done) begin
               le_d = 1'b0;
               cnt_d = CNT_W'(DLY_CYC);
               st_d = fpp_pkg::FPP_LE_LOW;
            end
         end
         fpp_pkg::FPP_LE_LOW: begin
            if (cnt_done) begin
               // one short: the pin value seen at the sample edge is four cycles old
               cnt_d = CNT_W'(SNS_CYC - 1);
               st_d = fpp_pkg::FPP_SENSE;
            end
         end
         fpp_pkg::FPP_SENSE: begin
            // sample at the end of the sensing window, never later
            if (cnt_done) begin
               le_d = 1'b1;
               rd_d = din_s;
               if (!sense_ok && op_q == fpp_pkg::FPP_OP_PROG && !retry_q) begin
                  retry_d = 1'b1;
                  vo2_d = 1'b1;
                  cnt_d = CNT_W'(DLY_CYC);
                  st_d = fpp_pkg::FPP_PRG_ON;
               end else begin
                  rp_d = sense_ok;
                  rr_d = retry_q;
                  cnt_d = CNT_W'(DLY_CYC);
                  st_d = fpp_pkg::FPP_VER_OFF;
               end
            end
         end
         fpp_pkg::FPP_VER_OFF: begin
            vo1_d = 1'b0;
            if (cnt_done) begin
               le_d = 1'b0;
               st_d = fpp_pkg::FPP_DONE;
            end
         end
         fpp_pkg::FPP_PL_ON: begin
            do_d = exp_q;
            oe_d = {OUT_N{1'b1}};
            pl_d = 1'b1;
            if (cnt_done) begin
               cnt_d = CNT_W'(DLY_CYC);
               st_d = fpp_pkg::FPP_PL_OFF;
            end
         end
         fpp_pkg::FPP_PL_OFF: begin
            pl_d = 1'b0;
            if (cnt_done) begin
               oe_d = '0;
               do_d = '0;
               rp_d = 1'b1;
               rr_d = 1'b0;
               rd_d = exp_q;
               st_d = fpp_pkg::FPP_DONE;
            end
         end
         fpp_pkg::FPP_DONE: begin
            rv_d = 1'b1;
            st_d = fpp_pkg::FPP_IDLE;
         end
         default: st_d = fpp_pkg::FPP_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st_q <= fpp_pkg::FPP_IDLE;
         op_q <= fpp_pkg::FPP_OP_PROG;
         cnt_q <= CNT_W'(PWR_CYC);
         pwr_ok_q <= 1'b0;
         retry_q <= 1'b0;
         row_q <= '0;
         col_q <= '0;
         sel_q <= '0;
         exp_q <= '0;
         vo1_q <= 1'b0;
         vo2_q <= 1'b0;
         pl_q <= 1'b0;
         le_q <= 1'b1;
         do_q <= '0;
         oe_q <= '0;
         rv_q <= 1'b0;
         rp_q <= 1'b0;
         rr_q <= 1'b0;
         rd_q <= '0;
      end else begin
         st_q <= st_d;
         op_q <= op_d;
         cnt_q <= cnt_d;
         pwr_ok_q <= pwr_ok_d;
         retry_q <= retry_d;
         row_q <= row_d;
         col_q <= col_d;
         sel_q <= sel_d;
         exp_q <= exp_d;
         vo1_q <= vo1_d;
         vo2_q <= vo2_d;
         pl_q <= pl_d;
         le_q <= le_d;
         do_q <= do_d;
         oe_q <= oe_d;
         rv_q <= rv_d;
         rp_q <= rp_d;
         rr_q <= rr_d;
         rd_q <= rd_d;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign cmd_ready = (st_q == fpp_pkg::FPP_IDLE) && pwr_ok_q;
   assign rsp_valid = rv_q;
   assign rsp_pass = rp_q;
   assign rsp_retried = rr_q;
   assign rsp_data = rd_q;
   assign row_addr_o = row_q;
   assign col_addr_o = col_q;
   assign first_output_supply = vo1_q;
   assign second_output_supply = vo2_q;
   assign latch_force_load = pl_q;
   assign latch_transparency_control = le_q;
   assign dout_o = do_q;
   assign dout_oe = oe_q;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   chk_prog_needs_ver: assert property (@(posedge core_clk) disable iff (sys_rst)
      second_output_supply |-> first_output_supply)
      else $error("program supply raised without verify supply");
   chk_fuse_needs_prog: assert property (@(posedge core_clk) disable iff (sys_rst)
      (|dout_oe && first_output_supply) |-> second_output_supply)
      else $error("fuse enable driven outside program mode");
   chk_le_high_fuse: assert property (@(posedge core_clk) disable iff (sys_rst)
      second_output_supply |-> latch_transparency_control)
      else $error("latch enable low while fusing");
   chk_no_pl_in_prog: assert property (@(posedge core_clk) disable iff (sys_rst)
      latch_force_load |-> !first_output_supply && dout_oe == {OUT_N{1'b1}})
      else $error("latch_force_load overlaps programming");
   chk_prg_off_ver: assert property (@(posedge core_clk) disable iff (sys_rst)
      $fell(second_output_supply) |-> first_output_supply)
      else $error("verify supply dropped before program supply");
   chk_one_fuse: assert property (@(posedge core_clk) disable iff (sys_rst)
      (st_q == fpp_pkg::FPP_FUSE) |-> $onehot(dout_oe))
      else $error("more than one fuse selected");
   chk_pwrup_opaque: assert property (@(posedge core_clk) disable iff (sys_rst)
      !pwr_ok_q |-> latch_transparency_control && !cmd_ready)
      else $error("latches transparent before power-up time");
   chk_sense_window: assert property (@(posedge core_clk) disable iff (sys_rst)
      $rose(st_q == fpp_pkg::FPP_SENSE) |-> ##12 (st_q != fpp_pkg::FPP_SENSE))
      else $error("sense window overran");
   chk_ver_off_last: assert property (@(posedge core_clk) disable iff (sys_rst)
      $fell(first_output_supply) |-> !second_output_supply && dout_oe == '0)
      else $error("verify supply dropped while programming");
endmodule // fpp_host

// *** design/fpp_pkg.sv ***
package fpp_pkg;
   typedef enum logic [3:0] {
      FPP_IDLE   = 4'h0,
      FPP_SETUP  = 4'h1,
      FPP_VER_ON = 4'h3,
      FPP_PRG_ON = 4'h2,
      FPP_FUSE   = 4'h6,
      FPP_PRG_OFF = 4'h7,
      FPP_LE_LOW = 4'h5,
      FPP_SENSE  = 4'h4,
      FPP_VER_OFF = 4'hC,
      FPP_PL_ON  = 4'h8,
      FPP_PL_OFF = 4'h9,
      FPP_DONE   = 4'hD
   } fpp_state_t;
   typedef enum logic [1:0] {
      FPP_OP_PROG = 2'h0,
      FPP_OP_VERIFY = 2'h1,
      FPP_OP_LATCH_FORCE_LOAD = 2'h2
   } fpp_op_t;
endpackage

// *** design/fpp_sync.sv ***
`timescale 1ns/10ps
// three-stage input synchroniser; a change counts once stages two and three agree
module fpp_sync #(
   parameter int WIDTH = 8
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q;
   logic [WIDTH-1:0] s1_d, s2_d, s3_d, out_d;
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_bit
         always_comb begin
            s1_d[gi] = async_in[gi];
            s2_d[gi] = s1_q[gi];
            s3_d[gi] = s2_q[gi];
            out_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : out_q[gi];
         end
      end
   endgenerate
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         out_q <= '0;
      end else begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
         out_q <= out_d;
      end
   end
   assign sync_out = out_q;
endmodule // fpp_sync

// *** tb/fpp_dev_model.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// device model: fuse array, latches, security
// ----------------------------------------
module fpp_dev_model #(
   parameter int EASY_CYC = 5,
   parameter int HARD_CYC = 30,
   parameter logic [5:0] SEC_ROW = 6'h3F,
   parameter logic [3:0] SEC_COL = 4'hB,
   parameter logic [7:0] POL = 8'h00
) (
   input wire logic core_clk,
   input wire logic hard_fuse,
   input wire logic [5:0] row_addr,
   input wire logic [3:0] col_addr,
   input wire logic first_output_supply,
   input wire logic second_output_supply,
   input wire logic latch_force_load,
   input wire logic latch_transparency_control,
   input wire logic [7:0] dout_o,
   input wire logic [7:0] dout_oe,
   output logic [7:0] din_o
);
   logic [7:0] fuse_q [64][16];
   logic [7:0] latch_q;
   logic [7:0] last_q;
   logic [7:0] dev;
   logic [7:0] burn;
   logic fl_q;
   logic sec_blown;
   int burn_cnt;
   initial begin
      foreach (fuse_q[r, c]) fuse_q[r][c] = 8'h00;
      latch_q = 8'h00;
      last_q = 8'h00;
      fl_q = 1'b0;
      burn_cnt = 0;
   end
   assign sec_blown = fuse_q[SEC_ROW][SEC_COL][0];
   assign burn = dout_oe & dout_o;
   always_comb begin
      if (first_output_supply) begin
         if (!latch_transparency_control) begin
            dev = sec_blown ? 8'hFF : fuse_q[row_addr][col_addr];
         end else begin
            dev = ~last_q; // outputs driven to the complement of the last pin level, no stale level
         end
      end else begin
         dev = latch_q ^ POL;
      end
      din_o = burn | (~dout_oe & dev);
   end
   always @(posedge core_clk) begin
      last_q <= din_o;
      fl_q <= latch_force_load;
      // fuse only opens after enough continuous fuse-enable time
      if (first_output_supply && second_output_supply && |burn) begin
         burn_cnt <= burn_cnt + 1;
         if (burn_cnt + 1 >= (hard_fuse ? HARD_CYC : EASY_CYC)) begin
            fuse_q[row_addr][col_addr] <= fuse_q[row_addr][col_addr] | burn;
         end
      end else begin
         burn_cnt <= 0;
      end
      if (fl_q && !latch_force_load && !sec_blown) begin
         latch_q <= dout_o;
      end
   end
endmodule // fpp_dev_model

// *** tb/test_fuse_program_latch_force_load_control.sv ***
`timescale 1ns/10ps
module test_fuse_program_latch_force_load_control;
   logic core_clk, sys_rst, cmd_valid, cmd_ready, rsp_valid, rsp_pass, rsp_retried;
   logic [1:0] cmd_op;
   logic [5:0] cmd_row, row_addr_o, row_prev;
   logic [3:0] cmd_col, col_addr_o;
   logic [7:0] cmd_outsel, cmd_expect, rsp_data, dout_o, dout_oe, din_i;
   logic first_output_supply, second_output_supply, latch_force_load;
   logic latch_transparency_control, hard_fuse;
   int error_cnt = 0;
   int checks_done = 0;
   // ----------------------------------------
   // clock, instances
   // ----------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   fpp_host #(.OUT_N(8), .FUSE1_CYC(20), .FUSE2_CYC(40)) i_fpp_host (
      .core_clk(core_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_op(cmd_op), .cmd_row(cmd_row), .cmd_col(cmd_col), .cmd_outsel(cmd_outsel),
      .cmd_expect(cmd_expect), .rsp_valid(rsp_valid), .rsp_pass(rsp_pass),
      .rsp_retried(rsp_retried), .rsp_data(rsp_data), .row_addr_o(row_addr_o),
      .col_addr_o(col_addr_o), .first_output_supply(first_output_supply),
      .second_output_supply(second_output_supply), .latch_force_load(latch_force_load),
      .latch_transparency_control(latch_transparency_control), .dout_o(dout_o),
      .dout_oe(dout_oe), .din_i(din_i));
   fpp_dev_model i_fpp_dev_model (
      .core_clk(core_clk), .hard_fuse(hard_fuse), .row_addr(row_addr_o),
      .col_addr(col_addr_o), .first_output_supply(first_output_supply),
      .second_output_supply(second_output_supply), .latch_force_load(latch_force_load),
      .latch_transparency_control(latch_transparency_control), .dout_o(dout_o),
      .dout_oe(dout_oe), .din_o(din_i));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic mism(input string msg);
      error_cnt++;
      $display("MISMATCH t=%0t %s", $time, msg);
   endtask
   task automatic expect_eq(input logic [15:0] got, input logic [15:0] want, input string msg);
      checks_done++;
      if (got !== want) mism(msg);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // one request, held until taken, then wait for its answer
   task automatic do_cmd(input logic [1:0] op, input logic [5:0] row, input logic [3:0] col,
                         input logic [7:0] sel, input logic [7:0] exp);
      int n;
      @(negedge core_clk);
      cmd_op = op;
      cmd_row = row;
      cmd_col = col;
      cmd_outsel = sel;
      cmd_expect = exp;
      cmd_valid = 1'b1;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 200) begin
         @(negedge core_clk);
         n++;
      end
      @(negedge core_clk);
      cmd_valid = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 3000) begin
         @(negedge core_clk);
         n++;
      end
      if (n >= 3000) mism("no response");
      expect_eq({first_output_supply, second_output_supply}, 8'h00, "supplies left on");
   endtask
   // supply ordering and row address stability watched on every cycle
   always @(negedge core_clk) begin
      row_prev <= row_addr_o;
      if (!sys_rst) begin
         if (second_output_supply === 1'b1 && first_output_supply !== 1'b1) begin
            mism("second supply without first");
         end
         if (second_output_supply === 1'b1 && latch_transparency_control !== 1'b1) begin
            mism("latches open while programming");
         end
         if (first_output_supply === 1'b1 && row_addr_o !== row_prev) begin
            mism("address moved in verify mode");
         end
      end
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset;
      int n;
      expect_eq({first_output_supply, second_output_supply, latch_force_load}, 8'h00, "rst sup");
      expect_eq({latch_transparency_control, dout_oe}, 9'h100, "rst latch");
      sys_rst = 1'b0;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 100) begin
         @(negedge core_clk);
         n++;
      end
      expect_eq(8'(n >= 25 && n < 100), 8'h01, "ready too early or never");
      expect_eq(latch_transparency_control, 1'b1, "latch open after reset");
      expect_eq(din_i, 8'h00, "latches not cleared");
      $display("test reset done");
   endtask
   task automatic t_verify_blank;
      do_cmd(2'h1, 6'h05, 4'h3, 8'hFF, 8'h00);
      expect_eq(rsp_pass, 1'b1, "blank verify fail");
      expect_eq({row_addr_o, 2'h0}, {6'h05, 2'h0}, "row pins");
      expect_eq(col_addr_o, 4'h3, "col pins");
      $display("test verify blank done");
   endtask
   task automatic t_program;
      do_cmd(2'h0, 6'h27, 4'hB, 8'h04, 8'h04);
      expect_eq({rsp_pass, rsp_retried}, 8'h02, "program result");
      do_cmd(2'h1, 6'h27, 4'hB, 8'hFF, 8'h04);
      expect_eq({rsp_pass, rsp_data}, 9'h104, "reverify");
      do_cmd(2'h1, 6'h27, 4'hB, 8'hFF, 8'h00);
      expect_eq({rsp_pass, rsp_data}, 9'h004, "miss not seen");
      $display("test program done");
   endtask
   task automatic t_retry;
      hard_fuse = 1'b1;
      do_cmd(2'h0, 6'h3F, 4'h0, 8'h80, 8'h80);
      expect_eq({rsp_pass, rsp_retried}, 8'h03, "retry result");
      hard_fuse = 1'b0;
      $display("test retry done");
   endtask
   task automatic t_latch_force_load;
      do_cmd(2'h2, 6'h00, 4'h0, 8'h00, 8'hA5);
      @(negedge core_clk);
      expect_eq(din_i, 8'hA5, "latch_force_load value");
      $display("test latch_force_load done");
   endtask
   task automatic t_security;
      do_cmd(2'h0, 6'h3F, 4'hB, 8'h01, 8'h01);
      expect_eq(rsp_pass, 1'b1, "security program");
      do_cmd(2'h2, 6'h00, 4'h0, 8'h00, 8'h3C);
      @(negedge core_clk);
      expect_eq(din_i, 8'hA5, "latch_force_load not blocked");
      do_cmd(2'h1, 6'h05, 4'h3, 8'hFF, 8'hFF);
      expect_eq({rsp_pass, rsp_data}, 9'h1FF, "security verify");
      $display("test security done");
   endtask
   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial begin
      sys_rst = 1'b1;
      cmd_valid = 1'b0;
      cmd_op = 2'h0;
      cmd_row = 6'h00;
      cmd_col = 4'h0;
      cmd_outsel = 8'h00;
      cmd_expect = 8'h00;
      hard_fuse = 1'b0;
      repeat (3) @(negedge core_clk);
      t_reset();
      t_verify_blank();
      t_program();
      t_retry();
      t_latch_force_load();
      t_security();
      close_out();
   end
   initial begin
      #(20000 * 40);
      mism("watchdog expired");
      close_out();
   end
endmodule // test_fuse_program_latch_force_load_control
